// File: ltc_pkg.sv
// constants and types for the local time counter load, save and adjust block
// Behaviour
// - line stays high after octets until second ends
// - serial time out enable drives time on pps
// - serial time in enable picks parallel or serial load
// - save enable captures counter on strobe
// - load offset added on every load
// - adjust command adds or subtracts offset
// - adjust independent of load enable, sets done
// - load wins over adjust, sets conflict flag
// - flags stay set until written zero
// - addition carries up to two seconds
// - drift counter crossing threshold corrects one ns
// - drift counter ignores time reloads
// - larger threshold continues from present count
// - smaller threshold corrects now, clears counter
// - octets lsb first, start high, stop low
// - high pulse then twenty microseconds low
// - six seconds octets, date and reserved zero
// - strobe rising edge loads staged time
package ltc_pkg;
	localparam int CLK_MHZ = 125;
	localparam logic [31:0] STEP_NS = 32'h0000_0008;
	localparam logic [31:0] ONE_NS = 32'h0000_0001;
	localparam logic [31:0] NS_1SEC = 32'h3B9A_CA00;
	localparam logic [31:0] NS_2SEC = 32'h7735_9400;
	localparam logic [47:0] SEC_ONE = 48'h0000_0000_0001;
	localparam logic [47:0] SEC_TWO = 48'h0000_0000_0002;
	// serial time segment durations
	localparam int PULSE_TIME_NS = 500;
	localparam int WAIT_TIME_US = 20;
	localparam int BIT_TIME_US = 1;
	localparam int HUNT_TIME_US = 10;
	localparam logic [11:0] PULSE_CYC = 12'((PULSE_TIME_NS * CLK_MHZ + 999) / 1000);
	localparam logic [11:0] WAIT_CYC = 12'(WAIT_TIME_US * CLK_MHZ);
	localparam logic [11:0] BIT_CYC = 12'(BIT_TIME_US * CLK_MHZ);
	localparam logic [11:0] HALF_BIT_CYC = 12'(BIT_TIME_US * CLK_MHZ / 2);
	localparam logic [11:0] HUNT_CYC = 12'(HUNT_TIME_US * CLK_MHZ);
	localparam logic [11:0] CYC_ONE = 12'h001;
	localparam logic [3:0] START_BIT = 4'h0;
	localparam logic [3:0] STOP_BIT = 4'h9;
	localparam logic [3:0] LAST_OCT = 4'hF;
	localparam logic [3:0] SEC_OCT_LAST = 4'h5;
	localparam logic [3:0] CNT_ONE = 4'h1;
	// register byte offsets
	localparam logic [11:0] CTRL_OFF = 12'h000;
	localparam logic [11:0] LOAD_SEC_L_OFF = 12'h004;
	localparam logic [11:0] LOAD_SEC_H_OFF = 12'h008;
	localparam logic [11:0] LOAD_NS_OFF = 12'h00C;
	localparam logic [11:0] SAVED_SEC_L_OFF = 12'h010;
	localparam logic [11:0] SAVED_SEC_H_OFF = 12'h014;
	localparam logic [11:0] SAVED_NS_OFF = 12'h018;
	localparam logic [11:0] LOAD_OFFSET_OFF = 12'h01C;
	localparam logic [11:0] ADJUST_OFF = 12'h020;
	localparam logic [11:0] ADJ_STATUS_OFF = 12'h024;
	localparam logic [11:0] DRIFT_THR_OFF = 12'h028;
	localparam logic [11:0] DRIFT_CNT_OFF = 12'h02C;
	localparam logic [11:0] TIME_SEC_L_OFF = 12'h030;
	localparam logic [11:0] TIME_NS_OFF = 12'h034;
	// control field positions
	localparam int LOAD_EN_BIT = 0;
	localparam int SAVE_EN_BIT = 1;
	localparam int SER_IN_BIT = 2;
	localparam int SER_OUT_BIT = 3;
	localparam int SW_LOAD_BIT = 4;
	localparam int DRIFT_UPD_BIT = 5;
	localparam int DRIFT_ADD_BIT = 6;
	localparam int ADJ_DIR_BIT = 30;
	localparam int ADJ_CMD_BIT = 31;
	localparam int DONE_BIT = 0;
	localparam int CONFLICT_BIT = 1;
	localparam logic [6:0] CTRL_RESET = 7'h00;

	typedef struct packed {
		logic [47:0] sec;
		logic [29:0] ns;
	} tod_t;

	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_PULSE = 2'b01,
		TX_WAIT = 2'b10,
		TX_OCTET = 2'b11
	} tx_state_t;

	typedef enum logic [1:0] {
		RX_HUNT = 2'b00,
		RX_ARMED = 2'b01,
		RX_BITS = 2'b10
	} rx_state_t;
endpackage : ltc_pkg

// File: pin_sync.sv
// two-stage pin synchroniser with rising edge detect
`timescale 1ns/1ns
`default_nettype none
module pin_sync (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// pin and synchronised view
	input wire logic pin,
	output logic level,
	output logic rise
);
	logic meta_reg;
	logic sync_reg;
	logic last_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
			last_reg <= 1'b0;
		end else begin
			meta_reg <= pin;
			sync_reg <= meta_reg;
			last_reg <= sync_reg;
		end
	end

	assign level = sync_reg;
	assign rise = sync_reg & ~last_reg;
endmodule : pin_sync
`default_nettype wire

// File: time_counter_load_adjust.sv
// local time counter with load, save, offset adjust, drift and serial time
//
// Implementation choices: register access over APB and the address map.
`timescale 1ns/1ns
`default_nettype none
module time_counter_load_adjust
	import ltc_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// pins
	input wire logic load_save_pin,
	output logic pps_out
);
	logic [6:0] ctrl_reg;
	tod_t load_reg;
	tod_t saved_reg;
	tod_t time_reg;
	tod_t time_next;
	logic [29:0] load_offset_value;
	logic [29:0] adjust_offset_value;
	logic adjust_direction;
	logic adjust_command;
	logic cmd_prev_reg;
	logic adjust_done_flag;
	logic adjust_conflict_flag;
	logic [29:0] drift_interval_threshold;
	logic [29:0] drift_interval_counter;
	logic strobe_level;
	logic strobe_rise;

	pin_sync u_strobe_sync (
		.pclk(pclk),
		.presetn(presetn),
		.pin(load_save_pin),
		.level(strobe_level),
		.rise(strobe_rise)
	);

	// apb decode
	wire wr_en = psel & penable & pwrite;
	wire setup = psel & ~penable;
	// strobe and address passed in, so a continuous assign sees every input change
	function automatic logic wr_hit(input logic en, input logic [11:0] a, input logic [11:0] off);
		return en && (a == off);
	endfunction : wr_hit
	wire addr_ok = (paddr <= TIME_NS_OFF) && (paddr[1:0] == 2'b00);
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~addr_ok;

	wire wr_ctrl = wr_hit(wr_en, paddr, CTRL_OFF);
	wire wr_status = wr_hit(wr_en, paddr, ADJ_STATUS_OFF);
	wire wr_thr = wr_hit(wr_en, paddr, DRIFT_THR_OFF);
	wire load_en = ctrl_reg[LOAD_EN_BIT];
	wire save_en = ctrl_reg[SAVE_EN_BIT];
	wire serial_time_in_enable = ctrl_reg[SER_IN_BIT];
	wire serial_time_out_enable = ctrl_reg[SER_OUT_BIT];
	wire drift_add = ctrl_reg[DRIFT_ADD_BIT];
	wire sw_load = wr_ctrl & pwdata[SW_LOAD_BIT];
	wire drift_interval_update = wr_ctrl & pwdata[DRIFT_UPD_BIT];

	// serial receive state
	rx_state_t rx_state;
	logic [11:0] rx_timer;
	logic [3:0] rx_bit;
	logic [3:0] rx_oct;
	logic [7:0] rx_shift;
	logic [47:0] rx_sec;
	logic rx_done;

	// load selection: disabled load enable blocks strobe and serial loads, not sw load
	wire par_load = strobe_rise & load_en & ~serial_time_in_enable;
	wire ser_load = rx_done & load_en & serial_time_in_enable;
	wire any_load = par_load | ser_load | sw_load;
	wire save_fire = strobe_rise & save_en;
	tod_t load_src;
	assign load_src = ser_load ? tod_t'{sec: rx_sec, ns: 30'h0} : load_reg;

	// adjust: only the rising edge of the command acts
	wire adj_req = adjust_command & ~cmd_prev_reg;
	wire adj_fire = adj_req & ~any_load;
	wire adj_conflict = adj_req & any_load;

	// drift correction runs on its own count, blind to reloads
	wire [31:0] drift_sum = {2'b00, drift_interval_counter} + STEP_NS;
	wire drift_on = drift_interval_threshold != 30'h0;
	wire drift_fire = drift_on && (drift_sum >= {2'b00, drift_interval_threshold});
	wire [31:0] drift_step = drift_add ? STEP_NS + ONE_NS : STEP_NS - ONE_NS;
	wire [31:0] step = drift_fire ? drift_step : STEP_NS;

	function automatic tod_t tod_add(input tod_t t, input logic [31:0] add);
		logic [31:0] s;
		tod_t r;
		s = {2'b00, t.ns} + add;
		r = t;
		if (s >= NS_2SEC) begin
			r.ns = 30'(s - NS_2SEC);
			r.sec = t.sec + SEC_TWO;
		end else if (s >= NS_1SEC) begin
			r.ns = 30'(s - NS_1SEC);
			r.sec = t.sec + SEC_ONE;
		end else begin
			r.ns = s[29:0];
		end
		return r;
	endfunction : tod_add

	// a borrow below zero seconds would wrap; callers must not ask for it
	function automatic tod_t tod_sub(input tod_t t, input logic [29:0] off);
		tod_t r;
		r = t;
		if (t.ns >= off) begin
			r.ns = t.ns - off;
		end else begin
			r.ns = 30'({2'b00, t.ns} + NS_1SEC - {2'b00, off});
			r.sec = t.sec - SEC_ONE;
		end
		return r;
	endfunction : tod_sub

	wire [31:0] adj_sum = step + {2'b00, adjust_offset_value};
	tod_t run_time;
	tod_t adj_time;
	tod_t loaded_time;
	assign run_time = tod_add(time_reg, step);
	assign adj_time = adjust_direction ? tod_add(time_reg, adj_sum) :
		tod_sub(run_time, adjust_offset_value);
	assign loaded_time = tod_add(load_src, {2'b00, load_offset_value});
	assign time_next = any_load ? loaded_time : (adj_fire ? adj_time : run_time);
	wire sec_tick = (time_next.sec != time_reg.sec) & ~any_load;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			time_reg <= '0;
			saved_reg <= '0;
			cmd_prev_reg <= 1'b0;
		end else begin
			time_reg <= time_next;
			cmd_prev_reg <= adjust_command;
			if (save_fire) begin
				saved_reg <= time_reg;
			end
		end
	end

	// flags: hardware set beats a software clear in the same cycle
	wire done_next = adj_fire | (adjust_done_flag & ~(wr_status & ~pwdata[DONE_BIT]));
	wire conflict_next = adj_conflict |
		(adjust_conflict_flag & ~(wr_status & ~pwdata[CONFLICT_BIT]));
	wire [29:0] drift_next = (drift_fire | drift_interval_update) ? 30'h0 : drift_sum[29:0];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			adjust_done_flag <= 1'b0;
			adjust_conflict_flag <= 1'b0;
			drift_interval_counter <= 30'h0;
		end else begin
			adjust_done_flag <= done_next;
			adjust_conflict_flag <= conflict_next;
			drift_interval_counter <= drift_next;
		end
	end

	// software registers; sw load and update bits act once and are not stored
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= CTRL_RESET;
			load_reg <= '0;
			load_offset_value <= 30'h0;
			adjust_offset_value <= 30'h0;
			adjust_direction <= 1'b0;
			adjust_command <= 1'b0;
			drift_interval_threshold <= 30'h0;
		end else begin
			if (wr_ctrl) ctrl_reg <= pwdata[6:0] & ~7'h30;
			if (wr_hit(wr_en, paddr, LOAD_SEC_L_OFF)) load_reg.sec[31:0] <= pwdata;
			if (wr_hit(wr_en, paddr, LOAD_SEC_H_OFF)) load_reg.sec[47:32] <= pwdata[15:0];
			if (wr_hit(wr_en, paddr, LOAD_NS_OFF)) load_reg.ns <= pwdata[29:0];
			if (wr_hit(wr_en, paddr, LOAD_OFFSET_OFF)) load_offset_value <= pwdata[29:0];
			if (wr_hit(wr_en, paddr, ADJUST_OFF)) begin
				adjust_offset_value <= pwdata[29:0];
				adjust_direction <= pwdata[ADJ_DIR_BIT];
				adjust_command <= pwdata[ADJ_CMD_BIT];
			end
			if (wr_thr) drift_interval_threshold <= pwdata[29:0];
		end
	end

	// read mux, captured in the setup cycle so prdata is a flop
	wire [31:0] rd_data =
		(paddr == CTRL_OFF) ? {25'h0, ctrl_reg} :
		(paddr == LOAD_SEC_L_OFF) ? load_reg.sec[31:0] :
		(paddr == LOAD_SEC_H_OFF) ? {16'h0, load_reg.sec[47:32]} :
		(paddr == LOAD_NS_OFF) ? {2'b00, load_reg.ns} :
		(paddr == SAVED_SEC_L_OFF) ? saved_reg.sec[31:0] :
		(paddr == SAVED_SEC_H_OFF) ? {16'h0, saved_reg.sec[47:32]} :
		(paddr == SAVED_NS_OFF) ? {2'b00, saved_reg.ns} :
		(paddr == LOAD_OFFSET_OFF) ? {2'b00, load_offset_value} :
		(paddr == ADJUST_OFF) ? {adjust_command, adjust_direction, adjust_offset_value} :
		(paddr == ADJ_STATUS_OFF) ? {30'h0, adjust_conflict_flag, adjust_done_flag} :
		(paddr == DRIFT_THR_OFF) ? {2'b00, drift_interval_threshold} :
		(paddr == DRIFT_CNT_OFF) ? {2'b00, drift_interval_counter} :
		(paddr == TIME_SEC_L_OFF) ? time_reg.sec[31:0] :
		(paddr == TIME_NS_OFF) ? {2'b00, time_reg.ns} : 32'h0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
		end else if (setup) begin
			prdata <= rd_data;
		end
	end

	// serial receiver on the strobe pin
	wire rx_mid = rx_timer == HALF_BIT_CYC - CYC_ONE;
	wire rx_end = rx_timer == BIT_CYC - CYC_ONE;
	wire rx_stop = rx_mid && (rx_bit == STOP_BIT);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_state <= RX_HUNT;
			rx_timer <= 12'h0;
			rx_bit <= 4'h0;
			rx_oct <= 4'h0;
			rx_shift <= 8'h0;
			rx_sec <= 48'h0;
			rx_done <= 1'b0;
		end else begin
			rx_done <= 1'b0;
			if (!serial_time_in_enable) begin
				rx_state <= RX_HUNT;
				rx_timer <= 12'h0;
			end else begin
				unique case (rx_state)
					RX_HUNT: begin
						// a 10 us low run only occurs in the waiting segment
						rx_oct <= 4'h0;
						rx_timer <= strobe_level ? 12'h0 : rx_timer + CYC_ONE;
						if (!strobe_level && rx_timer == HUNT_CYC - CYC_ONE) begin
							rx_state <= RX_ARMED;
						end
					end
					RX_ARMED: begin
						rx_timer <= 12'h0;
						rx_bit <= START_BIT;
						if (strobe_rise) rx_state <= RX_BITS;
					end
					RX_BITS: begin
						rx_timer <= rx_end ? 12'h0 : rx_timer + CYC_ONE;
						if (rx_end) rx_bit <= rx_bit + CNT_ONE;
						if (rx_mid && rx_bit != START_BIT && rx_bit != STOP_BIT) begin
							rx_shift <= {strobe_level, rx_shift[7:1]};
						end
						if (rx_stop) begin
							if (strobe_level) begin
								rx_state <= RX_HUNT;
							end else begin
								// date and reserved octets are dropped
								if (rx_oct <= SEC_OCT_LAST) rx_sec <= {rx_sec[39:0], rx_shift};
								rx_oct <= rx_oct + CNT_ONE;
								rx_state <= (rx_oct == LAST_OCT) ? RX_HUNT : RX_ARMED;
								rx_done <= rx_oct == LAST_OCT;
							end
						end
					end
					default: rx_state <= RX_HUNT;
				endcase
			end
		end
	end

	// serial transmitter on the pps pin
	tx_state_t tx_state;
	logic [11:0] tx_timer;
	logic [3:0] tx_bit;
	logic [3:0] tx_oct;
	logic [47:0] tx_sec;
	wire [47:0] tx_shifted = tx_sec >> {3'b000, SEC_OCT_LAST - tx_oct, 3'b000};
	wire [7:0] tx_octet = (tx_oct <= SEC_OCT_LAST) ? tx_shifted[7:0] : 8'h00;
	wire tx_data = tx_octet[3'(tx_bit - CNT_ONE)];
	wire tx_level = (tx_bit == START_BIT) ? 1'b1 : ((tx_bit == STOP_BIT) ? 1'b0 : tx_data);
	wire tx_bit_end = tx_timer == BIT_CYC - CYC_ONE;
	wire pps_next = !serial_time_out_enable ? 1'b0 :
		(tx_state == TX_IDLE) ? 1'b1 :
		(tx_state == TX_PULSE) ? 1'b1 :
		(tx_state == TX_WAIT) ? 1'b0 : tx_level;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_state <= TX_IDLE;
			tx_timer <= 12'h0;
			tx_bit <= 4'h0;
			tx_oct <= 4'h0;
			tx_sec <= 48'h0;
			pps_out <= 1'b0;
		end else begin
			pps_out <= pps_next;
			tx_timer <= tx_timer + CYC_ONE;
			if (!serial_time_out_enable) begin
				tx_state <= TX_IDLE;
			end else if (sec_tick) begin
				tx_state <= TX_PULSE;
				tx_sec <= time_next.sec;
				tx_timer <= 12'h0;
			end else begin
				unique case (tx_state)
					TX_IDLE: tx_timer <= 12'h0;
					TX_PULSE: begin
						if (tx_timer == PULSE_CYC - CYC_ONE) begin
							tx_state <= TX_WAIT;
							tx_timer <= 12'h0;
						end
					end
					TX_WAIT: begin
						if (tx_timer == WAIT_CYC - CYC_ONE) begin
							tx_state <= TX_OCTET;
							tx_timer <= 12'h0;
							tx_bit <= START_BIT;
							tx_oct <= 4'h0;
						end
					end
					TX_OCTET: begin
						if (tx_bit_end) begin
							tx_timer <= 12'h0;
							tx_bit <= (tx_bit == STOP_BIT) ? START_BIT : tx_bit + CNT_ONE;
							if (tx_bit == STOP_BIT) begin
								tx_oct <= tx_oct + CNT_ONE;
								if (tx_oct == LAST_OCT) tx_state <= TX_IDLE;
							end
						end
					end
				endcase
			end
		end
	end

	property p_done_set;
		@(posedge pclk) disable iff (!presetn)
		adj_fire |=> adjust_done_flag;
	endproperty
	a_done_set: assert property (p_done_set) else $error("done not set");

	property p_conflict;
		@(posedge pclk) disable iff (!presetn)
		adj_req && any_load |=> adjust_conflict_flag && time_reg == $past(loaded_time);
	endproperty
	a_conflict: assert property (p_conflict) else $error("load did not win");

	property p_flag_hold;
		@(posedge pclk) disable iff (!presetn)
		adjust_done_flag && !wr_status |=> adjust_done_flag;
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("done dropped");

	property p_single_adjust;
		@(posedge pclk) disable iff (!presetn)
		adj_req ##1 adjust_command |-> !adj_req;
	endproperty
	a_single_adjust: assert property (p_single_adjust) else $error("repeat adjust");

	property p_save;
		@(posedge pclk) disable iff (!presetn)
		save_fire |=> saved_reg == $past(time_reg);
	endproperty
	a_save: assert property (p_save) else $error("save missed");

	property p_drift_clear;
		@(posedge pclk) disable iff (!presetn)
		drift_fire |=> drift_interval_counter == 30'h0;
	endproperty
	a_drift_clear: assert property (p_drift_clear) else $error("drift not cleared");

	property p_wait_low;
		@(posedge pclk) disable iff (!presetn)
		$rose(tx_state == TX_WAIT) && serial_time_out_enable |=> !pps_out [*8];
	endproperty
	a_wait_low: assert property (p_wait_low) else $error("wait not low");

	property p_idle_high;
		@(posedge pclk) disable iff (!presetn)
		tx_state == TX_IDLE && serial_time_out_enable && !sec_tick |=> pps_out;
	endproperty
	a_idle_high: assert property (p_idle_high) else $error("idle not high");

	property p_par_load;
		@(posedge pclk) disable iff (!presetn)
		par_load && load_offset_value == 30'h0 && {2'b00, load_reg.ns} < NS_1SEC
		|=> time_reg == $past(load_reg);
	endproperty
	a_par_load: assert property (p_par_load) else $error("load value wrong");

	property p_no_op;
		@(posedge pclk) disable iff (!presetn)
		strobe_rise && !load_en && !sw_load |-> !any_load;
	endproperty
	a_no_op: assert property (p_no_op) else $error("load without enable");
endmodule : time_counter_load_adjust
`default_nettype wire

// File: time_ref_model.sv
// far-side time reference: strobe driver, serial time sender and receiver
`timescale 1ns/1ns
`default_nettype none
module time_ref_model (
	// clock
	input wire logic pclk,
	// pins
	output logic line_out,
	input wire logic pps_in
);
	logic [7:0] rx_oct [16];
	int rx_low;
	int rx_bad;

	initial line_out = 1'b0;

	task automatic hold(input logic v, input int n);
		line_out <= v;
		repeat (n) @(posedge pclk);
	endtask : hold

	// strobe rises k cycles on, idles low again
	task automatic strobe(input int k);
		repeat (k) @(posedge pclk);
		hold(1'b1, 4);
		hold(1'b0, 4);
	endtask : strobe

	// one frame; line left high as idle afterwards
	task automatic send(input logic [7:0] oct [16]);
		hold(1'b1, 63);
		hold(1'b0, 2500);
		for (int o = 0; o < 16; o++) begin
			hold(1'b1, 125);
			for (int b = 0; b < 8; b++) hold(oct[o][b], 125);
			hold(1'b0, 125);
		end
		hold(1'b1, 1);
	endtask : send

	// sampled mid-bit on the falling clock so the value is settled
	task automatic receive();
		rx_low = 0;
		rx_bad = 0;
		@(negedge pps_in);
		@(negedge pclk);
		while (pps_in === 1'b0) begin
			rx_low++;
			@(negedge pclk);
		end
		repeat (61) @(negedge pclk);
		for (int i = 0; i < 160; i++) begin
			if (i % 10 == 0 && pps_in !== 1'b1) rx_bad++;
			else if (i % 10 == 9 && pps_in !== 1'b0) rx_bad++;
			else if (i % 10 != 0 && i % 10 != 9) rx_oct[i / 10][i % 10 - 1] = pps_in;
			repeat (125) @(negedge pclk);
		end
		repeat (1000) begin
			if (pps_in !== 1'b1) rx_bad++;
			@(negedge pclk);
		end
	endtask : receive
endmodule : time_ref_model
`default_nettype wire

// File: time_counter_load_adjust_tb.sv
// self-checking bench for the local time counter load, save and adjust block
`timescale 1ns/1ns
`default_nettype none
module time_counter_load_adjust_tb import ltc_pkg::*;;
	typedef struct packed {
		logic err;
		logic [31:0] lo;
		logic [31:0] hi;
	} note_t;
	logic pclk;
	logic presetn;
	logic [11:0] paddr;
	logic psel;
	logic penable;
	logic pwrite;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic pin;
	logic pps_out;
	logic [31:0] rd_last;
	logic [31:0] seed;
	logic [31:0] ns0;
	logic [47:0] sv;
	logic [7:0] ex;
	logic [7:0] oct [16];
	note_t notes [$];
	note_t nt;
	int err_count;
	int compares;
	int hits;

	time_counter_load_adjust time_counter_load_adjust_inst (.pclk(pclk), .presetn(presetn),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .load_save_pin(pin),
		.pps_out(pps_out));
	time_ref_model time_ref_model_inst (.pclk(pclk), .line_out(pin), .pps_in(pps_out));

	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	task automatic chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
		compares++;
		if ((got >= lo && got <= hi) !== 1'b1) begin
			err_count++;
			$display("BAD %0t got %h want %h..%h", $time, got, lo, hi);
		end
	endtask : chk

	// request held until pready is seen high at a rising edge
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd_last = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(a, 1'b1, d);
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [31:0] lo, input logic [31:0] hi,
		input logic e = 1'b0);
		notes.push_back('{e, lo, hi});
		apb(a, 1'b0, 32'h0000_0000);
	endtask : rd

	// read results judged where they appear, oldest note first
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			nt = notes.pop_front();
			chk({31'h0, pslverr}, {31'h0, nt.err}, {31'h0, nt.err});
			chk(prdata, nt.lo, nt.hi);
		end
	end

	task automatic close_out();
		$display("errors %0d compares %0d", err_count, compares);
		if (err_count == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : close_out

	initial begin
		#720000;
		err_count++;
		close_out();
	end

	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		presetn = 1'b0;
		seed = 32'h0000_80C2;
		err_count = 0;
		compares = 0;
		hits = 0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(CTRL_OFF, 32'h0, 32'h0);
		rd(ADJ_STATUS_OFF, 32'h0, 32'h0);
		rd(12'h038, 32'h0, 32'h0, 1'b1);
		rd(12'h006, 32'h0, 32'h0, 1'b1);
		// parallel load with save, then save alone, then nothing
		seed = lfsr(seed);
		ns0 = {4'h0, seed[27:0]};
		wr(LOAD_SEC_L_OFF, 32'h0000_0005);
		wr(LOAD_SEC_H_OFF, 32'h0000_0000);
		wr(LOAD_NS_OFF, ns0);
		wr(LOAD_OFFSET_OFF, 32'h0000_0064);
		wr(CTRL_OFF, 32'h0000_0003);
		time_ref_model_inst.strobe(0);
		rd(TIME_SEC_L_OFF, 32'h5, 32'h5);
		rd(TIME_NS_OFF, ns0 + 32'h64, ns0 + 32'h190);
		rd(SAVED_SEC_L_OFF, 32'h0, 32'h0);
		wr(CTRL_OFF, 32'h0000_0002);
		time_ref_model_inst.strobe(0);
		rd(SAVED_SEC_L_OFF, 32'h5, 32'h5);
		rd(SAVED_NS_OFF, ns0 + 32'h64, ns0 + 32'h320);
		wr(LOAD_SEC_L_OFF, 32'h0000_0009);
		wr(CTRL_OFF, 32'h0000_0000);
		time_ref_model_inst.strobe(0);
		rd(TIME_SEC_L_OFF, 32'h5, 32'h5);
		// offset adjust: add with carry, one-shot, sticky flags, subtract back
		wr(ADJUST_OFF, 32'h7B9A_C9FF);
		wr(ADJUST_OFF, 32'hFB9A_C9FF);
		repeat (20) @(posedge pclk);
		rd(ADJ_STATUS_OFF, 32'h1, 32'h1);
		rd(TIME_SEC_L_OFF, 32'h6, 32'h6);
		wr(ADJ_STATUS_OFF, 32'h0000_0003);
		rd(ADJ_STATUS_OFF, 32'h1, 32'h1);
		wr(ADJ_STATUS_OFF, 32'h0000_0000);
		wr(ADJUST_OFF, 32'h3B9A_C9FF);
		wr(ADJUST_OFF, 32'hBB9A_C9FF);
		repeat (20) @(posedge pclk);
		rd(ADJ_STATUS_OFF, 32'h1, 32'h1);
		rd(TIME_SEC_L_OFF, 32'h5, 32'h5);
		// slide a strobe load across the adjust: exactly one collision
		wr(LOAD_SEC_L_OFF, 32'h0000_0005);
		wr(LOAD_OFFSET_OFF, 32'h0000_0000);
		wr(CTRL_OFF, 32'h0000_0001);
		for (int k = 0; k < 12; k++) begin
			wr(ADJ_STATUS_OFF, 32'h0000_0000);
			wr(ADJUST_OFF, 32'h4000_0010);
			fork
				time_ref_model_inst.strobe(k);
				begin
					repeat (6) @(posedge pclk);
					wr(ADJUST_OFF, 32'hC000_0010);
				end
			join
			rd(ADJ_STATUS_OFF, 32'h1, 32'h2);
			if (rd_last === 32'h0000_0002) hits++;
		end
		chk(32'(hits), 32'h1, 32'h1);
		// drift counter: update clears, low threshold wraps, high continues
		wr(DRIFT_THR_OFF, 32'h0000_0FA0);
		wr(CTRL_OFF, 32'h0000_0060);
		repeat (300) @(posedge pclk);
		rd(DRIFT_CNT_OFF, 32'h960, 32'h9C4);
		rd(CTRL_OFF, 32'h40, 32'h40);
		wr(DRIFT_THR_OFF, 32'h0000_0050);
		rd(DRIFT_CNT_OFF, 32'h0, 32'h4F);
		wr(DRIFT_THR_OFF, 32'h0000_0FA0);
		repeat (300) @(posedge pclk);
		rd(DRIFT_CNT_OFF, 32'h960, 32'hA00);
		// serial load; idle high long enough to flush any half frame
		wr(CTRL_OFF, 32'h0000_0000);
		wr(LOAD_OFFSET_OFF, 32'h0000_0000);
		time_ref_model_inst.hold(1'b1, 1300);
		wr(CTRL_OFF, 32'h0000_0004);
		wr(CTRL_OFF, 32'h0000_0005);
		sv = 48'h0000_1234_5678;
		for (int o = 0; o < 16; o++) begin
			seed = lfsr(seed);
			oct[o] = (o < 6) ? sv[8 * (5 - o) +: 8] : seed[7:0];
		end
		time_ref_model_inst.send(oct);
		rd(TIME_SEC_L_OFF, 32'h1234_5678, 32'h1234_5678);
		// serial output across a second boundary
		wr(CTRL_OFF, 32'h0000_0000);
		wr(LOAD_SEC_L_OFF, 32'h0000_0102);
		wr(LOAD_SEC_H_OFF, 32'h0000_00AB);
		wr(LOAD_NS_OFF, 32'h3B9A_A2F0);
		wr(CTRL_OFF, 32'h0000_0018);
		time_ref_model_inst.receive();
		chk(32'(time_ref_model_inst.rx_low), 32'h9C4, 32'h9C4);
		chk(32'(time_ref_model_inst.rx_bad), 32'h0, 32'h0);
		sv = 48'h00AB_0000_0103;
		for (int o = 0; o < 16; o++) begin
			ex = (o < 6) ? sv[8 * (5 - o) +: 8] : 8'h00;
			chk({24'h0, time_ref_model_inst.rx_oct[o]}, {24'h0, ex}, {24'h0, ex});
		end
		close_out();
	end
endmodule : time_counter_load_adjust_tb
`default_nettype wire
